// ### logic/pbs_seq.sv
`timescale 1ns/1ps
module pbs_seq import pbs_pkg::*; #(
   parameter int REWRITE_CYC = REFRESH_CYC // rewrite time, shorten in simulation
) (
   input wire logic ref_clk, // 20 MHz core clock
   input wire logic rst, // async reset, active high
   input wire logic cs_n, // serial chip select, active low
   input wire logic sck, // serial clock
   input wire logic si, // serial data in
   output logic so_o, // serial data out value
   output logic so_oe, // serial data out drive enable
   input wire logic page_bin, // 1 = 512-byte binary pages
   input wire logic protect_on, // sector protection enabled
   input wire logic lock_cmd_allowed, // lockdown command still enabled
   input wire logic buf1_prog_suspended, // program suspended using buffer one
   input wire logic buf2_prog_suspended, // program suspended using buffer two
   input wire logic erase_halted_flag, // some erase is suspended
   input wire logic ext_busy, // other self-timed operation running
   input wire logic ext_fault_we, // other program/erase finished
   input wire logic ext_fault_val, // its outcome, 1 = failed
   input wire logic arr_mismatch, // compare engine: page differs
   input wire logic arr_fault, // program engine: rewrite failed
   output logic arr_go, // one-cycle start to array engine
   output pbs_aop_e arr_op, // operation being started
   output logic arr_buf, // 0 = buffer one, 1 = buffer two
   output logic [PAGE_W-1:0] arr_page, // page index to operate on
   output logic erase_program_fault, // status: last program or erase failed
   output logic busy // any self-timed operation running
);

   pbs_link_if lnk ();

   pbs_pin_sync u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .cs_n(cs_n),
      .sck(sck),
      .si(si),
      .lnk(lnk)
   );

   pbs_seq_s q;
   pbs_seq_s d;

   logic [7:0] opcode;
   logic [23:0] addr;
   logic ready;
   logic [7:0] stat_one;
   logic [7:0] stat_two;
   logic [7:0] stat_byte;
   logic launch;
   pbs_aop_e req_op;
   logic req_buf;
   logic blocked;

   // page index from the address field in either size mode
   function automatic logic [PAGE_W-1:0] page_of(input logic [23:0] a, input logic bin);
      logic [PAGE_W-1:0] p;
      if (bin) begin
         p = a[PAGE_LSB_BIN +: PAGE_W];
      end else begin
         p = a[PAGE_LSB_STD +: PAGE_W];
      end
      return p;
   endfunction

   // operation named by an opcode, none for anything else
   function automatic pbs_aop_e op_of(input logic [7:0] op);
      pbs_aop_e r;
      r = AOP_NONE;
      if (op == OP_COPY_B1 || op == OP_COPY_B2) begin
         r = AOP_COPY;
      end
      if (op == OP_CHECK_B1 || op == OP_CHECK_B2) begin
         r = AOP_CHECK;
      end
      if (op == OP_REWRITE_B1 || op == OP_REWRITE_B2) begin
         r = AOP_REWRITE;
      end
      return r;
   endfunction

   // buffer chosen by an opcode: the three B2 opcodes pick buffer two, all others buffer one
   function automatic logic buf_of(input logic [7:0] op);
      logic b;
      b = (op == OP_COPY_B2) || (op == OP_CHECK_B2) || (op == OP_REWRITE_B2);
      return b;
   endfunction

   assign opcode = q.cmd_sh[31:24];
   assign addr = q.cmd_sh[23:0];

   // ready whenever neither this block nor the rest of the device runs
   assign busy = (q.state != ST_IDLE) | ext_busy;
   assign ready = ~busy;

   // status bytes are built live so every byte carries fresh values
   always_comb begin
      stat_one = 8'h00;
      stat_one[S1_READY] = ready;
      stat_one[S1_MISMATCH] = q.mismatch;
      stat_one[S1_DENSITY_LSB +: 4] = DENSITY_CODE;
      stat_one[S1_PROTECT] = protect_on;
      stat_one[S1_PAGE_BIN] = page_bin;
   end

   // bits 6 and 4 stay at their cleared value
   always_comb begin
      stat_two = 8'h00;
      stat_two[S2_READY] = ready;
      stat_two[S2_FAULT] = q.fault;
      stat_two[S2_LOCK_OK] = lock_cmd_allowed;
      stat_two[S2_PS2] = buf2_prog_suspended;
      stat_two[S2_PS1] = buf1_prog_suspended;
      stat_two[S2_ERASE_HALT] = erase_halted_flag;
   end

   // second half of each 16-bit cycle sends byte two
   assign stat_byte = q.scnt[3] ? stat_two : stat_one;

   // command decode at select release: full command, exactly four bytes
   always_comb begin
      req_op = op_of(opcode);
      req_buf = buf_of(opcode);
      blocked = 1'b0;
      // compare only reads the buffer, so suspension does not block it
      if (req_op == AOP_COPY || req_op == AOP_REWRITE) begin
         blocked = req_buf ? buf2_prog_suspended : buf1_prog_suspended;
      end
      launch = lnk.cs_end && !q.stat && (q.bitcnt == BITS_COMMAND) &&
               (req_op != AOP_NONE) && !busy && !blocked;
   end

   // next-state logic for the whole sequencer
   always_comb begin
      d = q;
      d.arr_go = 1'b0;

      // command shifter: bits taken on sck rise while selected
      if (lnk.cs_on && lnk.sck_rise && !q.stat) begin
         d.cmd_sh = {q.cmd_sh[30:0], lnk.si_bit};
         if (q.bitcnt != 6'h3f) begin
            d.bitcnt = q.bitcnt + 6'h01;
         end
         // status read needs only the opcode, and is taken while busy too
         if (q.bitcnt == BITS_OPCODE - 6'h01 && {q.cmd_sh[6:0], lnk.si_bit} == OP_STATUS) begin
            d.stat = 1'b1;
            d.scnt = 4'h0;
            d.so_oe = 1'b1;
         end
      end

      // status stream: next bit put out on each sck fall
      if (q.stat && lnk.cs_on && lnk.sck_fall) begin
         if (q.scnt[2:0] == 3'h0) begin
            // latch a fresh byte at each byte boundary
            d.so = stat_byte[7];
            d.so_sh = stat_byte[6:0];
         end else begin
            d.so = q.so_sh[6];
            d.so_sh = {q.so_sh[5:0], 1'b0};
         end
         d.scnt = q.scnt + 4'h1; // wraps from byte two back to byte one
      end

      // select release ends any transfer, even mid-byte
      if (lnk.cs_end || !lnk.cs_on) begin
         d.stat = 1'b0;
         d.so_oe = 1'b0;
         d.scnt = 4'h0;
      end
      if (lnk.cs_end) begin
         d.bitcnt = 6'h00;
      end

      // self-timed operations
      unique case (q.state)
         ST_IDLE: begin
            if (launch) begin
               d.arr_go = 1'b1;
               d.arr_op = req_op;
               d.arr_buf = req_buf;
               d.arr_page = page_of(addr, page_bin);
               unique case (req_op)
                  AOP_COPY: begin
                     d.state = ST_COPY;
                     d.tmr = TMR_W'(COPY_CYC - 1);
                  end
                  AOP_CHECK: begin
                     d.state = ST_CHECK;
                     d.tmr = TMR_W'(CHECK_CYC - 1);
                  end
                  AOP_REWRITE: begin
                     d.state = ST_REWRITE;
                     d.tmr = TMR_W'(REWRITE_CYC - 1);
                  end
                  AOP_NONE: begin
                     d.state = ST_IDLE;
                  end
               endcase
            end
         end
         ST_COPY: begin
            if (q.tmr == '0) begin
               d.state = ST_IDLE;
            end else begin
               d.tmr = q.tmr - TMR_W'(1);
            end
         end
         ST_CHECK: begin
            if (q.tmr == '0) begin
               // result lands only when the compare is complete
               d.mismatch = arr_mismatch;
               d.state = ST_IDLE;
            end else begin
               d.tmr = q.tmr - TMR_W'(1);
            end
         end
         ST_REWRITE: begin
            if (q.tmr == '0) begin
               // rewrite is a program, so its outcome updates the fault flag
               d.fault = arr_fault;
               d.state = ST_IDLE;
            end else begin
               d.tmr = q.tmr - TMR_W'(1);
            end
         end
      endcase

      // other program/erase results; aborted ones never report here
      if (ext_fault_we) begin
         d.fault = ext_fault_val;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= SEQ_RST;
      end else begin
         q <= d;
      end
   end

   // outputs straight from flops
   assign so_o = q.so;
   assign so_oe = q.so_oe;
   assign arr_go = q.arr_go;
   assign arr_op = q.arr_op;
   assign arr_buf = q.arr_buf;
   assign arr_page = q.arr_page;
   assign erase_program_fault = q.fault;

endmodule

// ### logic/pbs_pkg.sv
package pbs_pkg;

   // opcodes as they arrive on the serial input
   localparam logic [7:0] OP_COPY_B1 = 8'h53;
   localparam logic [7:0] OP_COPY_B2 = 8'h55;
   localparam logic [7:0] OP_CHECK_B1 = 8'h60;
   localparam logic [7:0] OP_CHECK_B2 = 8'h61;
   localparam logic [7:0] OP_REWRITE_B1 = 8'h58;
   localparam logic [7:0] OP_REWRITE_B2 = 8'h59;
   localparam logic [7:0] OP_STATUS = 8'hd7;

   // command framing: one opcode byte, three address bytes
   localparam logic [5:0] BITS_OPCODE = 6'h08;
   localparam logic [5:0] BITS_COMMAND = 6'h20;

   // page index position inside the 24-bit address
   localparam int PAGE_W = 12;
   localparam int PAGE_LSB_STD = 10;
   localparam int PAGE_LSB_BIN = 9;

   // status byte one layout
   localparam int S1_READY = 7;
   localparam int S1_MISMATCH = 6;
   localparam int S1_DENSITY_LSB = 2;
   localparam int S1_PROTECT = 1;
   localparam int S1_PAGE_BIN = 0;
   // status byte two layout, bits 6 and 4 stay zero
   localparam int S2_READY = 7;
   localparam int S2_FAULT = 5;
   localparam int S2_LOCK_OK = 3;
   localparam int S2_PS2 = 2;
   localparam int S2_PS1 = 1;
   localparam int S2_ERASE_HALT = 0;

   // density code, value is arbitrary
   localparam logic [3:0] DENSITY_CODE = 4'h5;

   // self-timed durations in microseconds, counts at 20 MHz
   localparam int CLK_MHZ = 20;
   localparam int COPY_DURATION_US = 200;
   localparam int CHECK_DURATION_US = 200;
   localparam int REFRESH_DURATION_US = 25000;
   localparam int COPY_CYC = COPY_DURATION_US * CLK_MHZ;
   localparam int CHECK_CYC = CHECK_DURATION_US * CLK_MHZ;
   localparam int REFRESH_CYC = REFRESH_DURATION_US * CLK_MHZ;
   localparam int TMR_W = 20;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_COPY = 2'b01,
      ST_CHECK = 2'b10,
      ST_REWRITE = 2'b11
   } pbs_state_e;

   // array engine operation codes
   typedef enum logic [1:0] {
      AOP_NONE = 2'b00,
      AOP_COPY = 2'b01,
      AOP_CHECK = 2'b10,
      AOP_REWRITE = 2'b11
   } pbs_aop_e;

   typedef struct packed {
      logic sck_m, sck_s, sck_p;
      logic cs_m, cs_s, cs_p;
      logic si_m, si_s;
   } pbs_sync_s;

   // chip select idles deasserted (high)
   localparam pbs_sync_s SYNC_RST = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

   typedef struct packed {
      pbs_state_e state;
      logic [TMR_W-1:0] tmr;
      logic [5:0] bitcnt;
      logic [31:0] cmd_sh;
      logic stat;
      logic [3:0] scnt;
      logic [6:0] so_sh;
      logic so;
      logic so_oe;
      logic mismatch;
      logic fault;
      logic arr_go;
      pbs_aop_e arr_op;
      logic arr_buf;
      logic [PAGE_W-1:0] arr_page;
   } pbs_seq_s;

   localparam pbs_seq_s SEQ_RST = '0;

endpackage

// ### logic/pbs_link_if.sv
`timescale 1ns/1ps
// synchronised serial-link events shared between front end and sequencer
interface pbs_link_if;
   logic sck_rise;
   logic sck_fall;
   logic cs_on;
   logic cs_end;
   logic si_bit;
   modport src (output sck_rise, sck_fall, cs_on, cs_end, si_bit);
   modport dst (input sck_rise, sck_fall, cs_on, cs_end, si_bit);
endinterface

// ### logic/pbs_pin_sync.sv
`timescale 1ns/1ps
module pbs_pin_sync import pbs_pkg::*; (
   input wire logic ref_clk, // 20 MHz core clock
   input wire logic rst, // async reset, active high
   input wire logic cs_n, // chip select pin, active low
   input wire logic sck, // serial clock pin
   input wire logic si, // serial data in pin
   pbs_link_if.src lnk // synchronised events
);

   pbs_sync_s q;
   pbs_sync_s d;

   // two flops per pin, then a third stage on sck and cs_n for edge detection
   always_comb begin
      d = q;
      d.sck_m = sck;
      d.sck_s = q.sck_m;
      d.sck_p = q.sck_s;
      d.cs_m = cs_n;
      d.cs_s = q.cs_m;
      d.cs_p = q.cs_s;
      d.si_m = si;
      d.si_s = q.si_m;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= SYNC_RST;
      end else begin
         q <= d;
      end
   end

   // only second and third stages feed logic
   assign lnk.sck_rise = q.sck_s & ~q.sck_p;
   assign lnk.sck_fall = ~q.sck_s & q.sck_p;
   assign lnk.cs_on = ~q.cs_s;
   assign lnk.cs_end = q.cs_s & ~q.cs_p;
   assign lnk.si_bit = q.si_s;

endmodule

// ### bench/pbs_seq_assertions.sv
`timescale 1ns/1ps
module pbs_seq_assertions import pbs_pkg::*; #(
   parameter int REWRITE_CYC = REFRESH_CYC // rewrite time
) (
   input wire logic ref_clk, // core clock
   input wire logic rst, // async reset
   input wire logic cs_n, // select, active low
   input wire logic so_oe, // out enable
   input wire logic ext_busy, // other op running
   input wire logic ext_fault_we, // fault write
   input wire logic ext_fault_val, // fault value
   input wire logic buf1_prog_suspended, // buffer one held
   input wire logic buf2_prog_suspended, // buffer two held
   input wire logic arr_go, // start pulse
   input wire pbs_aop_e arr_op, // operation
   input wire logic arr_buf, // buffer
   input wire logic erase_program_fault, // fault flag
   input wire logic busy // busy
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [TMR_W-1:0] cnt_q;
   // busy cycles since the last launch; a stale op after ext busy is masked below
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) cnt_q <= '0;
      else if (arr_go) cnt_q <= TMR_W'(1);
      else if (busy) cnt_q <= cnt_q + TMR_W'(1);
   end
   sequence s_go;
      !$past(busy) && $past(cs_n, 2);
   endsequence
   sequence s_run;
      (busy && !arr_go) [*2];
   endsequence
   property p_launch;
      arr_go |-> s_go ##1 s_run;
   endproperty
   a_launch: assert property (p_launch) else $error("bad launch");
   property p_len;
      $fell(busy) && !$past(ext_busy) |-> cnt_q >= ((arr_op == AOP_COPY) ? COPY_CYC :
         (arr_op == AOP_CHECK) ? CHECK_CYC : REWRITE_CYC) && cnt_q <= ((arr_op ==
         AOP_COPY) ? COPY_CYC : (arr_op == AOP_CHECK) ? CHECK_CYC : REWRITE_CYC) + 2;
   endproperty
   a_len: assert property (p_len) else $error("busy length wrong");
   property p_op;
      arr_go |-> arr_op != AOP_NONE;
   endproperty
   a_op: assert property (p_op) else $error("no op at launch");
   property p_susp;
      arr_go && arr_op != AOP_CHECK |->
         !(arr_buf ? $past(buf2_prog_suspended) : $past(buf1_prog_suspended));
   endproperty
   a_susp: assert property (p_susp) else $error("held buffer modified");
   property p_fext;
      ext_fault_we |=> erase_program_fault == $past(ext_fault_val);
   endproperty
   a_fext: assert property (p_fext) else $error("fault not written");
   property p_fkeep;
      $changed(erase_program_fault) |-> $past(ext_fault_we) ||
         ($past(busy) && arr_op == AOP_REWRITE);
   endproperty
   a_fkeep: assert property (p_fkeep) else $error("fault changed");
   property p_float;
      $rose(cs_n) |-> ##[1:6] !so_oe;
   endproperty
   a_float: assert property (p_float) else $error("output still driven");
   property p_oe;
      so_oe |-> !$past(cs_n, 6);
   endproperty
   a_oe: assert property (p_oe) else $error("drive while deselected");
   property p_busy_ext;
      ext_busy |-> busy;
   endproperty
   a_busy_ext: assert property (p_busy_ext) else $error("ready while busy");
endmodule
bind pbs_seq pbs_seq_assertions #(.REWRITE_CYC(REWRITE_CYC)) u_pbs_seq_assertions (
   .ref_clk, .rst, .cs_n, .so_oe, .ext_busy, .ext_fault_we, .ext_fault_val,
   .buf1_prog_suspended, .buf2_prog_suspended, .arr_go, .arr_op, .arr_buf,
   .erase_program_fault, .busy);

// ### bench/pbs_host.sv
`timescale 1ns/1ps
module pbs_host (
   input wire logic ref_clk, // paces the link, 8 clocks a bit
   input wire logic so_o, // device serial out
   input wire logic so_oe, // device drive enable
   output logic cs_n, // select, active low
   output logic sck, // link clock, idles low
   output logic si // serial in
);
   logic so_last = 1'b0;
   // a released line toggles, so a stale bit never reads as valid
   wire logic so_w = so_oe ? so_o : ~so_last;
   always @(posedge ref_clk) so_last <= so_w;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   // shift n bits msb first, then clock nrd more and collect the output
   task automatic shift(input logic [31:0] d, input int n, input int nrd,
      output logic [31:0] rd);
      rd = '0;
      @(posedge ref_clk) cs_n <= 1'b0;
      // 4 clocks low, 4 clocks high: 400 ns per bit
      for (int i = 0; i < n + nrd; i++) begin
         si <= d[31];
         d = d << 1;
         repeat (4) @(posedge ref_clk);
         sck <= 1'b1;
         repeat (4) @(posedge ref_clk);
         if (i >= n) rd = {rd[30:0], so_w};
         sck <= 1'b0;
      end
      repeat (4) @(posedge ref_clk);
      cs_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
   endtask
endmodule

// ### bench/pbs_seq_bench.sv
`timescale 1ns/1ps
module pbs_seq_bench import pbs_pkg::*; ;
   localparam int RW = 400;
   localparam logic [7:0] OPS [6] = '{OP_COPY_B1, OP_COPY_B2, OP_CHECK_B1, OP_CHECK_B2,
      OP_REWRITE_B1, OP_REWRITE_B2};
   logic ref_clk, rst, cs_n, sck, si, so_o, so_oe, page_bin, protect_on, lock_cmd_allowed;
   logic buf1_prog_suspended, buf2_prog_suspended, erase_halted_flag, ext_busy, ext_fault_we;
   logic ext_fault_val, arr_mismatch, arr_fault, arr_go, arr_buf, erase_program_fault, busy;
   pbs_aop_e arr_op, go_op;
   logic [PAGE_W-1:0] arr_page, go_page, pg;
   logic go_buf, exp_mis, exp_flt;
   logic [31:0] rd, x;
   int num_errors, n_tests, go_cnt, cyc, g;
   pbs_seq #(.REWRITE_CYC(RW)) u_pbs_seq (.ref_clk, .rst, .cs_n, .sck, .si, .so_o, .so_oe,
      .page_bin, .protect_on, .lock_cmd_allowed, .buf1_prog_suspended, .buf2_prog_suspended,
      .erase_halted_flag, .ext_busy, .ext_fault_we, .ext_fault_val, .arr_mismatch,
      .arr_fault, .arr_go, .arr_op, .arr_buf, .arr_page, .erase_program_fault, .busy);
   pbs_host u_pbs_host (.ref_clk, .so_o, .so_oe, .cs_n, .sck, .si);
   function automatic logic [31:0] rnd();
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   // expected status pair from the flags the bench holds
   function automatic logic [15:0] st(input logic rdy);
      return {rdy, exp_mis, DENSITY_CODE, protect_on, page_bin, rdy, 1'b0, exp_flt, 1'b0,
         lock_cmd_allowed, buf2_prog_suspended, buf1_prog_suspended, erase_halted_flag};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // dummy address bits are random so that a decoder reading them shows up
   task automatic cmd(input logic [7:0] op, input int n);
      logic [23:0] a;
      a = 24'(rnd());
      if (page_bin) a[20:9] = pg;
      else a[21:10] = pg;
      u_pbs_host.shift({op, a}, n, 0, rd);
   endtask
   task automatic rdst(input int n);
      u_pbs_host.shift({OP_STATUS, 24'h0}, 8, n, rd);
   endtask
   task automatic waitidle();
      for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge ref_clk);
      chk(busy, 0);
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // launch monitor and hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (arr_go === 1'b1) begin
         go_cnt <= go_cnt + 1;
         {go_op, go_buf, go_page} <= {arr_op, arr_buf, arr_page};
      end
      if (cyc == 60000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   initial begin
      x = 32'ha38a;
      rst = 1'b1;
      {page_bin, protect_on, lock_cmd_allowed, erase_halted_flag, ext_busy} = '0;
      {buf1_prog_suspended, buf2_prog_suspended, ext_fault_we, ext_fault_val} = '0;
      {arr_mismatch, arr_fault, exp_mis, exp_flt} = '0;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk({so_oe, arr_go, erase_program_fault, busy}, 0);
      // every page operation, random flags, page and dummies
      for (int k = 0; k < 6; k++) begin
         g = go_cnt;
         @(posedge ref_clk);
         {page_bin, protect_on, lock_cmd_allowed, erase_halted_flag} <= 4'(rnd());
         {arr_mismatch, arr_fault} <= 2'(rnd());
         pg = 12'(rnd());
         @(posedge ref_clk);
         cmd(OPS[k], 32);
         chk(go_cnt - g, 1);
         chk({busy, go_op, go_buf, go_page}, {1'b1, 2'(k / 2 + 1), 1'(k % 2), pg});
         rdst(16);
         chk(rd[15:0], st(1'b0));
         waitidle();
         if (k / 2 == 1) exp_mis = arr_mismatch;
         if (k / 2 == 2) exp_flt = arr_fault; // few rewrites, far below sector budget
         rdst(16);
         chk(rd[15:0], st(1'b1));
      end
      // held buffers refuse, then a short frame is dropped
      buf1_prog_suspended <= 1'b1;
      buf2_prog_suspended <= 1'b1;
      g = go_cnt;
      cmd(OP_COPY_B1, 32);
      cmd(OP_REWRITE_B2, 32);
      buf2_prog_suspended <= 1'b0;
      cmd(OP_COPY_B2, 31);
      chk(go_cnt - g, 0);
      // outside fault write and outside busy, then a streamed read
      {ext_fault_val, ext_fault_we, ext_busy} <= 3'b111;
      @(posedge ref_clk);
      ext_fault_we <= 1'b0;
      exp_flt = 1'b1;
      cmd(OP_CHECK_B1, 32);
      chk(go_cnt - g, 0);
      rdst(32);
      chk(rd, {st(1'b0), st(1'b0)});
      rdst(13);
      chk(so_oe, 0);
      tally_and_finish();
   end
endmodule
